// ===== core/pmrl_device.sv
/*
 Target end of the management link: address and command decode, read byte,
 read word, block read, writes into a 256-byte register map, idle timeout
 and a sticky write lock.
 Assumes the controller drives the clock and does not stretch it.
*/
`timescale 1ns/100ps
//////////////////////////////////////////////////////////////////////////////
module pmrl_device
   import pmrl_pkg::*;
   #(parameter int TIMEOUT_CYCLES = TIMEOUT_CYCLES_DEF)
   (
   input wire logic clk,
   input wire logic rst_b,
   pmrl_link_if.target link,
   output logic lockFlag,
   output logic timeoutOn,
   output logic timeoutEvt
   );

   typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_CMD, ST_WR, ST_RD, ST_WAIT} pmrl_dstate_type;
   localparam int TOW = $clog2(TIMEOUT_CYCLES + 1);

   // Counter must hold at least one cycle
   if (TIMEOUT_CYCLES < 1) begin : gBadTimeout
      $error("TIMEOUT_CYCLES must be at least 1");
   end

   logic sclMeta_r, sclSync_r, sclPrev_r;
   logic sdaMeta_r, sdaSync_r, sdaPrev_r;
   pmrl_dstate_type state_r;
   logic [3:0] bitCnt_r;
   logic [7:0] shift_r;
   logic [7:0] ptr_r;
   logic ptrValid_r;
   logic [7:0] byteIdx_r;
   logic ackIn_r;
   logic sdaDrv_b_r;
   logic lock_r;
   logic [TOW-1:0] toCnt_r;
   logic toEvt_r;
   logic [7:0] regs [0:255];

   //////////////////////////////////////////////////////////////////////////
   // Pin synchronisers plus one delay stage for edge detection
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sclMeta_r <= 1'b1;
         sclSync_r <= 1'b1;
         sclPrev_r <= 1'b1;
         sdaMeta_r <= 1'b1;
         sdaSync_r <= 1'b1;
         sdaPrev_r <= 1'b1;
      end else begin
         sclMeta_r <= link.scl;
         sclSync_r <= sclMeta_r;
         sclPrev_r <= sclSync_r;
         sdaMeta_r <= link.sda;
         sdaSync_r <= sdaMeta_r;
         sdaPrev_r <= sdaSync_r;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Bus events, only from synchronised levels
   wire sclRise = sclSync_r & ~sclPrev_r;
   wire sclFall = ~sclSync_r & sclPrev_r;
   wire startDet = sclSync_r & sclPrev_r & sdaPrev_r & ~sdaSync_r;
   wire stopDet = sclSync_r & sclPrev_r & ~sdaPrev_r & sdaSync_r;
   wire busAct = (sclSync_r ^ sclPrev_r) | (sdaSync_r ^ sdaPrev_r);

   // Byte selection; the address pointer wraps within the map
   wire [7:0] curAddr = ptr_r + byteIdx_r;
   wire [7:0] nextAddr = curAddr + 8'h01;
   wire isBlock = ptr_r == BLOCK_CMD;
   wire [7:0] txTotal = isBlock ? 8'(BLOCK_LEN + 8'h01) : {6'h00, pmrl_rd_len(ptr_r)};
   wire [7:0] txByte = (isBlock && byteIdx_r == 8'h00) ? BLOCK_LEN : regs[curAddr];
   wire [7:0] txNext = (isBlock && byteIdx_r == 8'hff) ? BLOCK_LEN : regs[nextAddr];
   wire moreTx = 8'(byteIdx_r + 8'h01) < txTotal;
   wire addrHit = shift_r[7:1] == SLAVE_ADDR;
   wire wrRoom = byteIdx_r < {6'h00, pmrl_wr_len(ptr_r)};
   wire critical = curAddr >= CRIT_LO && curAddr <= CRIT_HI;

   // Read address is only taken once a command loaded the pointer
   wire ackRx = (state_r == ST_ADDR) ? (addrHit && (!shift_r[0] || ptrValid_r)) :
                (state_r == ST_CMD) ? 1'b1 : wrRoom;
   wire byteEnd = sclFall && bitCnt_r == 4'h8;
   wire wrByte = state_r == ST_WR && byteEnd && wrRoom;
   wire regWe = wrByte && !(lock_r && critical);
   wire toFire = timeoutOn && state_r != ST_IDLE && toCnt_r == TOW'(TIMEOUT_CYCLES - 1);

   //////////////////////////////////////////////////////////////////////////
   // Protocol engine; timeout and stop outrank everything else
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_r <= ST_IDLE;
         bitCnt_r <= 4'h0;
         shift_r <= 8'h00;
         ptr_r <= 8'h00;
         ptrValid_r <= 1'b0;
         byteIdx_r <= 8'h00;
         ackIn_r <= 1'b0;
         sdaDrv_b_r <= 1'b1;
      end else if (toFire || stopDet) begin
         state_r <= ST_IDLE;
         sdaDrv_b_r <= 1'b1;
         ptrValid_r <= 1'b0;
      end else if (startDet) begin
         // A repeated start keeps the pointer for the read that follows
         state_r <= ST_ADDR;
         bitCnt_r <= 4'h0;
         sdaDrv_b_r <= 1'b1;
      end else if (state_r == ST_IDLE || state_r == ST_WAIT) begin
         sdaDrv_b_r <= 1'b1;
      end else if (sclRise) begin
         if (bitCnt_r < 4'h9) bitCnt_r <= bitCnt_r + 4'h1;
         if (bitCnt_r < 4'h8 && state_r != ST_RD) shift_r <= {shift_r[6:0], sdaSync_r};
         if (bitCnt_r == 4'h8 && state_r == ST_RD) ackIn_r <= ~sdaSync_r;
      end else if (sclFall && state_r == ST_RD) begin
         if (bitCnt_r >= 4'h1 && bitCnt_r <= 4'h7) begin
            sdaDrv_b_r <= txByte[3'(4'h7 - bitCnt_r)];
         end else if (bitCnt_r == 4'h8) begin
            sdaDrv_b_r <= 1'b1; // Free the line for the controller's ack
         end else if (bitCnt_r == 4'h9) begin
            if (ackIn_r && moreTx) begin
               byteIdx_r <= byteIdx_r + 8'h01;
               bitCnt_r <= 4'h0;
               sdaDrv_b_r <= txNext[7];
            end else begin
               state_r <= ST_WAIT; // Count reached or no ack: stop sending
               sdaDrv_b_r <= 1'b1;
            end
         end
      end else if (byteEnd) begin
         sdaDrv_b_r <= ~ackRx;
         if (!ackRx) begin
            state_r <= ST_WAIT;
         end else if (state_r == ST_ADDR && shift_r[0]) begin
            state_r <= ST_RD;
            ackIn_r <= 1'b1;
            byteIdx_r <= 8'hff; // Next step rolls it to byte zero
         end else if (state_r == ST_ADDR) begin
            state_r <= ST_CMD;
         end else if (state_r == ST_CMD) begin
            ptr_r <= shift_r;
            ptrValid_r <= 1'b1;
            byteIdx_r <= 8'h00;
            state_r <= ST_WR;
         end else begin
            byteIdx_r <= byteIdx_r + 8'h01;
         end
      end else if (sclFall && bitCnt_r == 4'h9) begin
         bitCnt_r <= 4'h0;
         sdaDrv_b_r <= 1'b1;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Register map; an acknowledged data byte lands unless the lock is set and its address is in CRIT_LO..CRIT_HI
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < 256; i++) regs[i] <= REG_RESET;
      end else if (regWe) begin
         regs[curAddr] <= shift_r;
      end
   end

   // Lock is sticky; no command clears it, only the power-on reset
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) lock_r <= 1'b0;
      else if (wrByte && curAddr == LOCK_CMD && shift_r[LOCK_BIT]) lock_r <= 1'b1;
   end

   //////////////////////////////////////////////////////////////////////////
   // Idle timer; resets on any wire change so slow controllers stay safe
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         toCnt_r <= '0;
         toEvt_r <= 1'b0;
      end else begin
         toEvt_r <= toFire;
         if (busAct || state_r == ST_IDLE || toFire) toCnt_r <= '0;
         else toCnt_r <= toCnt_r + TOW'(1);
      end
   end

   assign timeoutOn = regs[CFG_CMD][CFG_TO_BIT];
   assign lockFlag = lock_r;
   assign timeoutEvt = toEvt_r;
   assign link.slvSdaDrv_b = sdaDrv_b_r;
endmodule : pmrl_device

// ===== core/pmrl_host.sv
/*
 Controller end of the management link: an APB slave register set that
 launches write, read byte, read word and block read transfers.
 Assumes a pull-up on the data wire and a target that does not stretch the clock.
*/
// The APB register port is this design's own decision.
`timescale 1ns/100ps
module pmrl_host
   import pmrl_pkg::*;
   #(parameter int QTR_CYCLES = QTR_CYCLES_DEF)
   (
   input wire logic clk,
   input wire logic rst_b,
   pmrl_link_if.ctrl link,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
   );

   typedef enum logic [3:0] {M_IDLE, M_START, M_ADDRW, M_CMD, M_WDATA, M_RSTART, M_ADDRR, M_RDATA,
                             M_STOP} pmrl_mstate_type;
   localparam int QW = $clog2(QTR_CYCLES);

   // Synchronised sampling needs several cycles per quarter bit
   if (QTR_CYCLES < 8) begin : gBadQtr
      $error("QTR_CYCLES must be at least 8");
   end

   pmrl_mstate_type state_r;
   pmrl_kind_type kind_r;
   logic [7:0] code_r;
   logic [1:0] nWr_r;
   logic [23:0] wdata_r;
   logic [31:0] rdata_r;
   logic busy_r, nack_r, done_r, ackBad_r;
   logic [QW-1:0] qCnt_r;
   logic [1:0] phase_r;
   logic [3:0] bitIdx_r;
   logic [1:0] byteCnt_r;
   logic [7:0] rdIdx_r;
   logic [8:0] total_r;
   logic [7:0] rxSh_r;
   logic sclOut_r, sdaDrv_b_r, sdaMeta_r, sdaSync_r;
   logic pready_r, pslverr_r;
   logic [31:0] prdata_r;

   //////////////////////////////////////////////////////////////////////////
   // APB decode; one wait-free access phase per transfer
   wire setup = psel & ~penable;
   wire xfer = psel & penable & pready_r;
   wire mapped = paddr == HOST_CMD_OFS || paddr == HOST_WDATA_OFS || paddr == HOST_STAT_OFS ||
                 paddr == HOST_RDATA_OFS;
   wire go = xfer && pwrite && paddr == HOST_CMD_OFS && pwdata[CMD_GO_BIT] && !busy_r;
   wire wdWe = xfer && pwrite && paddr == HOST_WDATA_OFS && !busy_r;
   wire [31:0] rdMux = (paddr == HOST_CMD_OFS) ? {18'h0, nWr_r, 2'h0, kind_r, code_r} :
                       (paddr == HOST_WDATA_OFS) ? {8'h00, wdata_r} :
                       (paddr == HOST_STAT_OFS) ? {29'h0, done_r, nack_r, busy_r} :
                       (paddr == HOST_RDATA_OFS) ? rdata_r : 32'h0;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0;
      end else begin
         pready_r <= setup;
         pslverr_r <= setup & ~mapped;
         if (setup && !pwrite) prdata_r <= rdMux;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Wanted wire levels for the current symbol and quarter
   wire txState = state_r == M_ADDRW || state_r == M_CMD || state_r == M_WDATA || state_r == M_ADDRR;
   wire [7:0] txByte = (state_r == M_ADDRW) ? {SLAVE_ADDR, 1'b0} :
                       (state_r == M_ADDRR) ? {SLAVE_ADDR, 1'b1} :
                       (state_r == M_CMD) ? code_r : wdata_r[{byteCnt_r, 3'b000} +: 8];
   wire isLast = (kind_r == KIND_BLOCK && rdIdx_r == 8'h00) ? (rxSh_r == 8'h00) :
                 (9'(rdIdx_r) + 9'h001 >= total_r);
   wire sdaWant = (state_r == M_IDLE) ? 1'b1 :
                  (state_r == M_START || state_r == M_RSTART) ? (phase_r < 2'h2) :
                  (state_r == M_STOP) ? (phase_r >= 2'h2) :
                  (bitIdx_r == 4'h8) ? (txState | isLast) :
                  (txState ? txByte[3'(4'h7 - bitIdx_r)] : 1'b1);
   wire sclWant = state_r == M_IDLE || phase_r == 2'h1 || phase_r == 2'h2 ||
                  (state_r == M_STOP && phase_r == 2'h3);
   wire qEnd = qCnt_r == QW'(QTR_CYCLES - 1);
   wire symEnd = qEnd && phase_r == 2'h3;
   wire byteDone = symEnd && bitIdx_r == 4'h8;

   //////////////////////////////////////////////////////////////////////////
   // Registered pins and data-line synchroniser
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sclOut_r <= 1'b1;
         sdaDrv_b_r <= 1'b1;
         sdaMeta_r <= 1'b1;
         sdaSync_r <= 1'b1;
      end else begin
         sclOut_r <= sclWant;
         sdaDrv_b_r <= sdaWant;
         sdaMeta_r <= link.sda;
         sdaSync_r <= sdaMeta_r;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Transfer sequencer, one step per quarter bit
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_r <= M_IDLE;
         kind_r <= KIND_WRITE;
         code_r <= 8'h00;
         nWr_r <= 2'h0;
         wdata_r <= 24'h0;
         rdata_r <= 32'h0;
         busy_r <= 1'b0;
         nack_r <= 1'b0;
         done_r <= 1'b0;
         ackBad_r <= 1'b0;
         qCnt_r <= '0;
         phase_r <= 2'h0;
         bitIdx_r <= 4'h0;
         byteCnt_r <= 2'h0;
         rdIdx_r <= 8'h00;
         total_r <= 9'h001;
         rxSh_r <= 8'h00;
      end else if (state_r == M_IDLE) begin
         if (wdWe) wdata_r <= pwdata[23:0];
         if (go) begin
            code_r <= pwdata[7:0];
            kind_r <= pmrl_kind_type'(pwdata[CMD_KIND_LSB +: 2]);
            nWr_r <= pwdata[CMD_NWR_LSB +: 2];
            rdata_r <= 32'h0;
            busy_r <= 1'b1;
            done_r <= 1'b0;
            nack_r <= 1'b0;
            qCnt_r <= '0;
            phase_r <= 2'h0;
            bitIdx_r <= 4'h0;
            state_r <= M_START;
         end
      end else if (!qEnd) begin
         qCnt_r <= qCnt_r + QW'(1);
      end else begin
         qCnt_r <= '0;
         phase_r <= phase_r + 2'h1;
         if (phase_r == 2'h2 && bitIdx_r < 4'h8) rxSh_r <= {rxSh_r[6:0], sdaSync_r};
         if (phase_r == 2'h2 && bitIdx_r == 4'h8) ackBad_r <= sdaSync_r;
         if (symEnd && bitIdx_r < 4'h8 && state_r != M_START && state_r != M_RSTART && state_r != M_STOP) begin
            bitIdx_r <= bitIdx_r + 4'h1;
         end
         if (symEnd && state_r == M_START) state_r <= M_ADDRW;
         if (symEnd && state_r == M_RSTART) state_r <= M_ADDRR;
         if (symEnd && state_r == M_STOP) begin
            state_r <= M_IDLE;
            busy_r <= 1'b0;
            done_r <= 1'b1;
         end
         if (byteDone) begin
            bitIdx_r <= 4'h0;
            if (txState && ackBad_r) begin
               nack_r <= 1'b1;
               state_r <= M_STOP;
            end else if (state_r == M_ADDRW) begin
               state_r <= M_CMD;
            end else if (state_r == M_CMD && kind_r == KIND_WRITE) begin
               state_r <= (nWr_r == 2'h0) ? M_STOP : M_WDATA;
               byteCnt_r <= 2'h0;
            end else if (state_r == M_CMD) begin
               state_r <= M_RSTART;
            end else if (state_r == M_WDATA) begin
               byteCnt_r <= byteCnt_r + 2'h1;
               if (byteCnt_r + 2'h1 == nWr_r) state_r <= M_STOP;
            end else if (state_r == M_ADDRR) begin
               state_r <= M_RDATA;
               rdIdx_r <= 8'h00;
               total_r <= (kind_r == KIND_RWORD) ? 9'h002 : 9'h001;
            end else begin
               if (rdIdx_r < 8'h04) rdata_r[{rdIdx_r[1:0], 3'b000} +: 8] <= rxSh_r;
               if (kind_r == KIND_BLOCK && rdIdx_r == 8'h00) total_r <= 9'(rxSh_r) + 9'h001;
               if (isLast) state_r <= M_STOP;
               else rdIdx_r <= rdIdx_r + 8'h01;
            end
         end
      end
   end

   assign link.scl = sclOut_r;
   assign link.mstSdaDrv_b = sdaDrv_b_r;
   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
endmodule : pmrl_host

// ===== core/pmrl_link_if.sv
/*
 Two-wire link between controller and target.
 Assumes a pull-up on the data wire: it is low when either end pulls it.
*/
`timescale 1ns/100ps
interface pmrl_link_if;
   logic scl;
   logic mstSdaDrv_b;
   logic slvSdaDrv_b;
   logic sda;

   // Wired-AND of both open-drain drivers
   assign sda = mstSdaDrv_b & slvSdaDrv_b;

   modport ctrl (output scl, output mstSdaDrv_b, input sda);
   modport target (input scl, input sda, output slvSdaDrv_b);
endinterface : pmrl_link_if

// ===== core/pmrl_pkg.sv
/*
 Shared constants for the serial management link: the target's command map,
 timing counts and the controller's register offsets.
 Assumes a 40 MHz system clock on both ends.
*/
package pmrl_pkg;
   // Bus address of the target; a neutral value, change per board
   localparam logic [6:0] SLAVE_ADDR = 7'h2c;
   // Command map of the target
   localparam logic [7:0] CFG_CMD = 8'hd1;
   localparam int CFG_TO_BIT = 3;
   localparam logic [7:0] LOCK_CMD = 8'hd2;
   localparam int LOCK_BIT = 0;
   localparam logic [7:0] CRIT_LO = 8'h20;
   localparam logic [7:0] CRIT_HI = 8'h2f;
   localparam logic [7:0] WORD_LO = 8'h80;
   localparam logic [7:0] WORD_HI = 8'h8f;
   localparam logic [7:0] TRI_LO = 8'ha0;
   localparam logic [7:0] TRI_HI = 8'haf;
   localparam logic [7:0] BLOCK_CMD = 8'h9a;
   localparam logic [7:0] BLOCK_LEN = 8'h04;
   localparam logic [7:0] REG_RESET = 8'h00;
   // Timing
   localparam int CLK_HZ = 40_000_000;
   localparam int TIMEOUT_MS = 35;
   localparam int TIMEOUT_CYCLES_DEF = CLK_HZ / 1000 * TIMEOUT_MS;
   localparam int SCL_KHZ = 100;
   localparam int QTR_CYCLES_DEF = CLK_HZ / (SCL_KHZ * 1000 * 4);
   // Controller register offsets and fields
   localparam logic [7:0] HOST_CMD_OFS = 8'h00;
   localparam logic [7:0] HOST_WDATA_OFS = 8'h04;
   localparam logic [7:0] HOST_STAT_OFS = 8'h08;
   localparam logic [7:0] HOST_RDATA_OFS = 8'h0c;
   localparam int CMD_KIND_LSB = 8;
   localparam int CMD_NWR_LSB = 12;
   localparam int CMD_GO_BIT = 31;

   typedef enum logic [1:0] {KIND_WRITE, KIND_RBYTE, KIND_RWORD, KIND_BLOCK} pmrl_kind_type;

   // Write length that a command code allows
   function automatic logic [1:0] pmrl_wr_len(input logic [7:0] c);
      if (c >= WORD_LO && c <= WORD_HI) return 2'h2;
      if (c >= TRI_LO && c <= TRI_HI) return 2'h3;
      return 2'h1;
   endfunction : pmrl_wr_len

   // Read length that a command code gives
   function automatic logic [1:0] pmrl_rd_len(input logic [7:0] c);
      if (c >= WORD_LO && c <= WORD_HI) return 2'h2;
      return 2'h1;
   endfunction : pmrl_rd_len
endpackage : pmrl_pkg

// ===== test/pmrl_link_assertions.sv
/*
 Checker for the two-wire link between host and device, plus the device flags.
 Assumes it is instantiated beside the interface with one clock and rst_b.
*/
`timescale 1ns/100ps
module pmrl_link_assertions #(parameter int TIMEOUT_CYCLES = 200) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic scl,
   input wire logic mstSdaDrv_b,
   input wire logic slvSdaDrv_b,
   input wire logic sda,
   input wire logic lockFlag,
   input wire logic timeoutOn,
   input wire logic timeoutEvt
);
   logic sclPrev_r;
   logic sdaPrev_r;
   int idleCnt_r;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   //////////////////////////////////////////////////////////////////////////
   // Cycles since either wire last moved; a stuck bus is judged against it
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sclPrev_r <= 1'b1;
         sdaPrev_r <= 1'b1;
         idleCnt_r <= 0;
      end else begin
         sclPrev_r <= scl;
         sdaPrev_r <= sda;
         idleCnt_r <= (scl != sclPrev_r || sda != sdaPrev_r) ? 0 : idleCnt_r + 1;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Wire and device relations
   AST_SDA_WIRED: assert property (sda == (mstSdaDrv_b & slvSdaDrv_b))
      else $error("data wire is not the AND of both drivers");
   // Device data and ack bits move only while the clock is low, else a start or stop is faked
   AST_SLV_SCL_LOW: assert property ($changed(slvSdaDrv_b) |-> !scl || timeoutEvt || $past(timeoutEvt))
      else $error("device moved the data wire with the clock high");
   AST_START_FREE: assert property (scl && $stable(scl) && $fell(sda) |-> slvSdaDrv_b)
      else $error("device holds the wire at a start");
   AST_LOCK_STICKY: assert property (lockFlag |=> lockFlag)
      else $error("lock flag cleared");
   AST_TO_ENABLED: assert property (timeoutEvt |-> timeoutOn)
      else $error("timeout fired while disabled");
   AST_TO_PULSE: assert property (timeoutEvt |=> !timeoutEvt)
      else $error("timeout event longer than one cycle");
   AST_TO_RELEASE: assert property (timeoutEvt |-> ##[0:2] slvSdaDrv_b ##1 slvSdaDrv_b)
      else $error("data wire not released after timeout");
   AST_TO_BOUND: assert property (timeoutOn && !slvSdaDrv_b |-> idleCnt_r < TIMEOUT_CYCLES + 8)
      else $error("device held a stuck bus past the timeout");

   CV_LOCK: cover property ($rose(lockFlag));
   CV_ACK: cover property ($fell(slvSdaDrv_b));
   CV_TO_ON: cover property ($rose(timeoutOn));
   CV_TO_EVT: cover property (timeoutEvt);
endmodule : pmrl_link_assertions

// ===== test/tb_pmbus_slave_read_timeout_lock.sv
/*
 Bench: host and device joined by one link; APB tasks drive the host.
 Assumes the core package, interface and both ends are compiled first.
*/
`timescale 1ns/100ps
module tb_pmbus_slave_read_timeout_lock;
   import pmrl_pkg::*;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic lockFlag;
   logic timeoutOn;
   logic timeoutEvt;
   logic [31:0] rd;
   logic [31:0] st;
   logic se;
   int err_count = 0;
   int compares = 0;
   int cycles = 0;
   // Host-only reset lets a scenario abandon a frame while the device is mid-transaction
   logic hostRun = 1'b1;
   wire hostRst_b = rst_b & hostRun;

   pmrl_link_if pmrl_link_if_inst();
   pmrl_device #(.TIMEOUT_CYCLES(200)) pmrl_device_inst (.clk(clk), .rst_b(rst_b), .link(pmrl_link_if_inst),
      .lockFlag(lockFlag), .timeoutOn(timeoutOn), .timeoutEvt(timeoutEvt));
   // Shortest legal bit time keeps the run brief
   pmrl_host #(.QTR_CYCLES(8)) pmrl_host_inst (.clk(clk), .rst_b(hostRst_b), .link(pmrl_link_if_inst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));
   pmrl_link_assertions #(.TIMEOUT_CYCLES(200)) pmrl_link_assertions_inst (.clk(clk), .rst_b(rst_b),
      .scl(pmrl_link_if_inst.scl), .mstSdaDrv_b(pmrl_link_if_inst.mstSdaDrv_b),
      .slvSdaDrv_b(pmrl_link_if_inst.slvSdaDrv_b), .sda(pmrl_link_if_inst.sda), .lockFlag(lockFlag),
      .timeoutOn(timeoutOn), .timeoutEvt(timeoutEvt));

   //////////////////////////////////////////////////////////////////////////
   // Clock and hang guard
   always #12.5 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 90000) begin
         err_count++;
         final_report();
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Shared tasks
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   // One APB transfer; pready is taken at the rising edge, as the host sees it
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      se = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Launch one link transfer, wait for done, then fetch received bytes
   task automatic xfer(input logic [7:0] code, input logic [1:0] kind, input logic [1:0] nwr,
         input logic [23:0] wd);
      int n;
      n = 0;
      apb(1'b1, HOST_WDATA_OFS, {8'h00, wd});
      apb(1'b1, HOST_CMD_OFS, {1'b1, 17'h0, nwr, 2'b00, kind, code});
      do begin
         apb(1'b0, HOST_STAT_OFS, 32'h0);
         n++;
      end while (rd[2] !== 1'b1 && n < 2000);
      st = rd;
      apb(1'b0, HOST_RDATA_OFS, 32'h0);
   endtask : xfer

   task automatic final_report;
      $display("compares=%0d errors=%0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : final_report

   //////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_reset;
      chk({31'h0, lockFlag}, 32'h0);
      chk({31'h0, timeoutOn}, 32'h0);
      apb(1'b0, 8'h10, 32'h0);
      chk({31'h0, se}, 32'h1);
      chk(rd, 32'h0);
      xfer(CFG_CMD, KIND_RBYTE, 2'h0, 24'h0);
      chk(rd & 32'hff, 32'h0);
      $display("test reset done");
   endtask : t_reset

   task automatic t_cfg;
      xfer(CFG_CMD, KIND_WRITE, 2'h1, 24'h08);
      chk({31'h0, timeoutOn}, 32'h1);
      xfer(CFG_CMD, KIND_RBYTE, 2'h0, 24'h0);
      chk(rd & 32'hff, 32'h08);
      $display("test config done");
   endtask : t_cfg

   task automatic t_byte;
      xfer(8'h40, KIND_WRITE, 2'h1, 24'h5a);
      xfer(8'h40, KIND_RBYTE, 2'h0, 24'h0);
      chk(st & 32'h2, 32'h0);
      chk(rd & 32'hff, 32'h5a);
      $display("test read byte done");
   endtask : t_byte

   task automatic t_word;
      xfer(WORD_LO, KIND_WRITE, 2'h2, 24'h1234);
      xfer(WORD_LO, KIND_RWORD, 2'h0, 24'h0);
      chk(rd & 32'hffff, 32'h1234);
      $display("test read word done");
   endtask : t_word

   task automatic t_block;
      for (int i = 0; i < 3; i++) begin
         xfer(BLOCK_CMD + 8'(i + 1), KIND_WRITE, 2'h1, 24'(8'hc0 + i));
      end
      xfer(BLOCK_CMD, KIND_BLOCK, 2'h0, 24'h0);
      chk(rd, {8'hc2, 8'hc1, 8'hc0, BLOCK_LEN});
      $display("test block read done");
   endtask : t_block

   task automatic t_lock;
      xfer(CRIT_LO, KIND_WRITE, 2'h1, 24'haa);
      xfer(LOCK_CMD, KIND_WRITE, 2'h1, 24'h01);
      chk({31'h0, lockFlag}, 32'h1);
      xfer(CRIT_LO, KIND_WRITE, 2'h1, 24'h55);
      xfer(CRIT_LO, KIND_RBYTE, 2'h0, 24'h0);
      chk(rd & 32'hff, 32'haa);
      xfer(LOCK_CMD, KIND_WRITE, 2'h1, 24'h00);
      chk({31'h0, lockFlag}, 32'h1);
      xfer(CRIT_LO, KIND_WRITE, 2'h1, 24'h66);
      xfer(CRIT_LO, KIND_RBYTE, 2'h0, 24'h0);
      chk(rd & 32'hff, 32'haa);
      $display("test lock done");
   endtask : t_lock

   // A single-byte command given two bytes: the extra one is refused and not stored
   task automatic t_nack;
      xfer(8'h41, KIND_WRITE, 2'h2, 24'h7777);
      chk(st & 32'h2, 32'h2);
      xfer(8'h42, KIND_RBYTE, 2'h0, 24'h0);
      chk(rd & 32'hff, 32'h0);
      $display("test overlong write done");
   endtask : t_nack

   // Host dropped mid-ack leaves the device holding the wire; the idle timer must free it
   task automatic t_timeout;
      int n;
      n = 0;
      apb(1'b1, HOST_CMD_OFS, {1'b1, 17'h0, 2'h0, 2'b00, 2'(KIND_RBYTE), CFG_CMD});
      do begin
         @(posedge clk);
      end while (pmrl_link_if_inst.slvSdaDrv_b !== 1'b0);
      repeat (4) @(posedge clk);
      hostRun <= 1'b0;
      do begin
         @(posedge clk);
         n++;
      end while (timeoutEvt !== 1'b1 && n < 400);
      chk({31'h0, n >= 200 && n <= 210}, 32'h1);
      chk({31'h0, pmrl_link_if_inst.slvSdaDrv_b}, 32'h1);
      hostRun <= 1'b1;
      repeat (3) @(posedge clk);
      xfer(CFG_CMD, KIND_RBYTE, 2'h0, 24'h0);
      chk(st & 32'h2, 32'h0);
      chk(rd & 32'hff, 32'h08);
      $display("test timeout done");
   endtask : t_timeout

   //////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk);
      t_reset();
      t_cfg();
      t_byte();
      t_word();
      t_block();
      t_lock();
      t_nack();
      t_timeout();
      final_report();
   end
endmodule : tb_pmbus_slave_read_timeout_lock
